// ---- sle_pkg.sv ----
// Constants, carrier types and states shared by the link error status block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
// Functional notes
// RULE1: Every detected fault is sorted into data, link or catastrophic class.
// RULE2: Bad code group, disparity fault or enabled CRC mismatch is a data error.
// RULE3: Packet marked bad by remote sender is a data error on regular port.
// RULE4: Data error in regular-port packet raises regular receive error flag.
// RULE5: Without resend option, priority packet data error raises priority error flag.
// RULE6: With resend option, bad priority packet is refused for resend; no flag.
// RULE7: Overflow of regular, priority or compensation buffer is a link error.
// RULE8: Loss of character alignment, lane alignment or signal is a link error.
// RULE9: Too many data errors within a short window escalate to link error.
// RULE10: Restart sequence received from far end is a link error.
// RULE11: Any link error takes the link down, then initialisation runs again.
// RULE12: Catastrophic error puts the link into a permanent dead state.
// RULE13: Status shows only local state; nothing from the far end.
// RULE14: Link-side status crosses into system clock by synchronisers, no FIFO.
// RULE15: Status bit 0 is high while the local link is up.
// RULE16: Status bit 1 rises the cycle after a catastrophic error.
// RULE17: Status bit 2 pulses one cycle whenever a link error drops the link.
// RULE18: Status bit 3 pulses one cycle per link cycle with data errors.
// RULE19: A data error alone never takes the link down.
// RULE20: Escalation count and window are build parameters with defaults.
`default_nettype none
package sle_pkg;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_ERRCNT     = 8'h08;
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_CLR_BIT   = 1;
    localparam logic        CTRL_EN_RESET  = 1'h1;
    localparam int unsigned STAT_STATE_POS = 4;
    localparam int unsigned ERRCNT_LINK_POS = 16;
    localparam int unsigned ERR_LIMIT_DEF  = 4;
    localparam int unsigned ERR_WINDOW_DEF = 64;
    localparam int unsigned CNT_W          = 16;

    typedef enum logic [1:0] {
        LINK_DOWN,
        LINK_INIT,
        LINK_UP,
        LINK_DEAD
    } sle_link_state_t;

    // Per-cycle indications from the lane logic in the recovered clock domain
    typedef struct packed {
        logic codeErr;
        logic dispErr;
        logic crcErr;
        logic txBadMark;
        logic pktValid;
        logic pktEnd;
        logic pktPriority;
        logic ovfRegular;
        logic ovfPriority;
        logic ovfClkComp;
        logic lossCharAlign;
        logic lossLaneAlign;
        logic lossSignal;
        logic restartSeen;
        logic polarityRev;
        logic laneRev;
        logic laneScrambled;
        logic alignDone;
    } sle_link_in_t;

    // Status port, bit 3 first
    typedef struct packed {
        logic dataErr;
        logic linkErr;
        logic catErr;
        logic linkUp;
    } sle_status_t;
endpackage
`default_nettype wire

// ---- sle_error_status.sv ----
// Error classification and local status of one end of a serial link.
// Assumes lane indications change with recClk, which is sampled here as
// an ordinary asynchronous input; registers reached over APB.
`default_nettype none
module sle_error_status #(
    parameter bit          CRC_EN         = 1'b1,
    parameter bit          RETRY_ON_ERROR = 1'b0,
    parameter bit          AUTO_POLARITY  = 1'b0,
    parameter bit          AUTO_LANE_REV  = 1'b0,
    parameter int unsigned ERR_LIMIT      = sle_pkg::ERR_LIMIT_DEF,   // see RULE20
    parameter int unsigned ERR_WINDOW     = sle_pkg::ERR_WINDOW_DEF   // see RULE20
) (
    input  wire logic                 clk_sys,        // System clock
    input  wire logic                 nrst,           // Async reset, low
    input  wire logic                 recClk,         // Recovered link clock
    input  wire sle_pkg::sle_link_in_t linkIn,        // Lane indications
    output var  sle_pkg::sle_status_t statusPort,     // Local status
    output logic                      rxRegularPacketError,  // Regular pkt bad
    output logic                      rxPriorityPacketError, // Priority pkt bad
    output logic                      priorityResendReq,     // Bad ack to sender
    output logic                      linkTrain,      // Run initialisation
    input  wire logic                 psel,           // APB select
    input  wire logic                 penable,        // APB enable
    input  wire logic                 pwrite,         // APB direction
    input  wire logic [7:0]           paddr,          // APB byte address
    input  wire logic [31:0]          pwdata,         // APB write data
    output logic [31:0]               prdata,         // APB read data
    output logic                      pready,         // APB ready
    output logic                      pslverr         // APB error
);
    localparam int unsigned CW = sle_pkg::CNT_W;
    localparam logic [CW-1:0] LIMIT  = CW'(ERR_LIMIT);
    localparam logic [CW-1:0] WINDOW = CW'(ERR_WINDOW);

    // Local names for the link states
    localparam sle_pkg::sle_link_state_t LINK_DOWN = sle_pkg::LINK_DOWN;
    localparam sle_pkg::sle_link_state_t LINK_INIT = sle_pkg::LINK_INIT;
    localparam sle_pkg::sle_link_state_t LINK_UP   = sle_pkg::LINK_UP;
    localparam sle_pkg::sle_link_state_t LINK_DEAD = sle_pkg::LINK_DEAD;

    // Saturating increment used by all counters
    function automatic logic [CW-1:0] incSat(input logic [CW-1:0] v);
        incSat = (v == {CW{1'b1}}) ? v : v + CW'(1);
    endfunction

    // Two-stage synchronisers for link clock and lane indications
    sle_pkg::sle_link_in_t inMeta, inSync;
    logic [2:0]            clkSh;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            inMeta <= '0;
            inSync <= '0;
            clkSh  <= 3'h0;
        end else begin
            inMeta <= linkIn;
            inSync <= inMeta;
            clkSh  <= {clkSh[1:0], recClk};
        end
    end

    // One system cycle per recovered clock rising edge
    logic linkEdge;
    assign linkEdge = clkSh[1] & ~clkSh[2];

    // Fault classification on each link cycle into data, link or fatal  see RULE1
    logic dataAny, linkFault, catDet, escalate;
    sle_pkg::sle_link_state_t state, next_state;
    logic [CW-1:0] winCnt, next_winCnt, errCnt, next_errCnt;
    logic          pktBad, next_pktBad;
    logic          linkEn;
    always_comb begin
        dataAny = inSync.codeErr | inSync.dispErr                       // see RULE2
                | (CRC_EN & inSync.crcErr)                              // see RULE2
                | (inSync.txBadMark & ~inSync.pktPriority);             // see RULE3
        // The tally restarts at a window edge, so that sample counts as the first
        escalate = dataAny                                              // see RULE9
                 && (((incSat(winCnt) >= WINDOW) ? CW'(1) : incSat(errCnt)) >= LIMIT);
        linkFault = inSync.ovfRegular | inSync.ovfPriority              // see RULE7
                  | inSync.ovfClkComp
                  | inSync.lossCharAlign | inSync.lossLaneAlign         // see RULE8
                  | inSync.lossSignal
                  | inSync.restartSeen                                  // see RULE10
                  | escalate;
        catDet = (inSync.polarityRev & ~AUTO_POLARITY)                  // see RULE12
               | (inSync.laneRev & ~AUTO_LANE_REV)
               | inSync.laneScrambled;
    end

    // Link state, escalation window and packet error tracking
    logic next_linkErrP, next_dataErrP, next_regErr, next_priErr, next_resend;
    logic linkDrop;
    always_comb begin
        next_state    = state;
        next_winCnt   = winCnt;
        next_errCnt   = errCnt;
        next_pktBad   = pktBad;
        next_regErr   = 1'b0;
        next_priErr   = 1'b0;
        next_resend   = 1'b0;
        next_dataErrP = 1'b0;
        linkDrop      = 1'b0;
        case (state)
            LINK_DOWN: begin
                next_errCnt = '0;
                next_winCnt = '0;
                next_pktBad = 1'b0;
                if (linkEn) begin
                    next_state = LINK_INIT;                             // see RULE11
                end
            end
            LINK_INIT: begin
                if (linkEdge && catDet) begin
                    next_state = LINK_DEAD;                             // see RULE12
                end else if (linkEdge && inSync.alignDone) begin
                    next_state = LINK_UP;
                end
            end
            LINK_UP: begin
                if (linkEdge) begin
                    // Count window restarts the error tally
                    if (incSat(winCnt) >= WINDOW) begin
                        next_winCnt = '0;
                        next_errCnt = dataAny ? CW'(1) : '0;
                    end else begin
                        next_winCnt = incSat(winCnt);
                        next_errCnt = dataAny ? incSat(errCnt) : errCnt;
                    end
                    next_dataErrP = dataAny;                            // see RULE18
                    // Packet verdict at end of packet
                    if (inSync.pktValid && inSync.pktEnd) begin
                        next_pktBad = 1'b0;
                        if (!inSync.pktPriority) begin
                            next_regErr = pktBad | dataAny;             // see RULE4
                        end else if (RETRY_ON_ERROR) begin
                            next_resend = pktBad | dataAny;             // see RULE6
                        end else begin
                            next_priErr = pktBad | dataAny;             // see RULE5
                        end
                    end else if (inSync.pktValid) begin
                        next_pktBad = pktBad | dataAny;
                    end
                    if (catDet) begin
                        next_state = LINK_DEAD;                         // see RULE12
                    end else if (linkFault) begin
                        next_state = LINK_DOWN;                         // see RULE11
                        linkDrop   = 1'b1;
                    end
                    // A data error alone leaves the link in this state  see RULE19
                end
            end
            LINK_DEAD: next_state = LINK_DEAD;                          // see RULE12
            default:   next_state = LINK_DOWN;
        endcase
        next_linkErrP = linkDrop;                                       // see RULE17
    end

    // Register link state; status reflects only local conditions  see RULE13
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state                 <= LINK_DOWN;
            winCnt                <= '0;
            errCnt                <= '0;
            pktBad                <= 1'b0;
            statusPort            <= '0;
            rxRegularPacketError  <= 1'b0;
            rxPriorityPacketError <= 1'b0;
            priorityResendReq     <= 1'b0;
            linkTrain             <= 1'b0;
        end else begin
            state                 <= next_state;
            winCnt                <= next_winCnt;
            errCnt                <= next_errCnt;
            pktBad                <= next_pktBad;
            statusPort.linkUp     <= (next_state == LINK_UP);           // see RULE15
            statusPort.catErr     <= (next_state == LINK_DEAD);         // see RULE16
            statusPort.linkErr    <= next_linkErrP;                     // see RULE17
            statusPort.dataErr    <= next_dataErrP;                     // see RULE18
            rxRegularPacketError  <= next_regErr;
            rxPriorityPacketError <= next_priErr & ~RETRY_ON_ERROR;     // see RULE6
            priorityResendReq     <= next_resend;
            linkTrain             <= (next_state == LINK_INIT);
        end
    end

    // APB slave: no wait states, reads captured in setup
    logic [CW-1:0] dataCount, next_dataCount, linkCount, next_linkCount;
    logic          next_linkEn, next_pready, next_pslverr;
    logic [31:0]   next_prdata;
    logic          wrDone, setup, clrCnt;
    always_comb begin
        setup        = psel & ~penable;
        wrDone       = psel & penable & pready & pwrite;
        next_pready  = setup;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        next_linkEn  = linkEn;
        clrCnt       = 1'b0;
        if (setup) begin
            case (paddr)
                sle_pkg::REG_CTRL: begin
                    next_prdata[sle_pkg::CTRL_EN_BIT] = linkEn;
                end
                sle_pkg::REG_STATUS: begin
                    next_prdata[3:0] = statusPort;
                    next_prdata[sle_pkg::STAT_STATE_POS +: 2] = state;
                end
                sle_pkg::REG_ERRCNT: begin
                    next_prdata = {linkCount, dataCount};
                end
                default: next_pslverr = 1'b1;
            endcase
            if (pwrite) begin
                next_prdata = '0;
            end
        end
        if (wrDone && paddr == sle_pkg::REG_CTRL) begin
            next_linkEn = pwdata[sle_pkg::CTRL_EN_BIT];
            clrCnt      = pwdata[sle_pkg::CTRL_CLR_BIT];
        end
        // A new event wins over a clear in the same cycle
        next_dataCount = clrCnt ? '0 : dataCount;
        next_linkCount = clrCnt ? '0 : linkCount;
        if (next_dataErrP) begin
            next_dataCount = incSat(next_dataCount);
        end
        if (next_linkErrP) begin
            next_linkCount = incSat(next_linkCount);
        end
    end

    // Register bus state and counters
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            linkEn    <= sle_pkg::CTRL_EN_RESET;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= '0;
            dataCount <= '0;
            linkCount <= '0;
        end else begin
            linkEn    <= next_linkEn;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            prdata    <= next_prdata;
            dataCount <= next_dataCount;
            linkCount <= next_linkCount;
        end
    end

    // Checks on classification and status timing
    a_dead_sticky: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE12
        state == LINK_DEAD |=> state == LINK_DEAD [*8])
        else $error("dead link left its state");
    a_cat_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE16
        (linkEdge && catDet && (state == LINK_UP || state == LINK_INIT))
        |=> statusPort.catErr && state == LINK_DEAD)
        else $error("catastrophic flag late");
    a_link_drop: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE11
        (state == LINK_UP && linkEdge && linkFault && !catDet)
        |=> state == LINK_DOWN ##1 linkTrain || !linkEn)
        else $error("link error did not restart");
    a_lerr_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE17
        $rose(statusPort.linkErr) |-> $past(state) == LINK_UP && !statusPort.linkUp
        ##1 !statusPort.linkErr)
        else $error("link error pulse wrong");
    a_up_level: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE15
        $rose(statusPort.linkUp) |-> $past(state) == LINK_INIT && $past(linkEdge)
        && $past(inSync.alignDone) && state == LINK_UP)
        else $error("link up bit mismatch");
    a_data_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE18
        (state == LINK_UP && linkEdge && dataAny) |=> statusPort.dataErr ##1 !statusPort.dataErr)
        else $error("data error pulse wrong");
    a_data_stays: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE19
        (state == LINK_UP && !(linkEdge && (linkFault || catDet))) |=> state == LINK_UP)
        else $error("link dropped without link error");
    a_reg_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE4
        (state == LINK_UP && linkEdge && inSync.pktValid && inSync.pktEnd
         && !inSync.pktPriority && (pktBad || dataAny)) |=> rxRegularPacketError)
        else $error("regular packet error missed");
    a_pri_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE5
        rxPriorityPacketError |-> !RETRY_ON_ERROR && $past(inSync.pktPriority))
        else $error("priority flag misused");
    a_resend: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE6
        priorityResendReq |-> RETRY_ON_ERROR && !rxPriorityPacketError)
        else $error("resend without option");

    // Main scenarios
    c_link_up: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(statusPort.linkUp));
    c_restart: cover property (@(posedge clk_sys) disable iff (!nrst)
        statusPort.linkErr ##[1:200] statusPort.linkUp);
    c_dead:    cover property (@(posedge clk_sys) disable iff (!nrst) $rose(statusPort.catErr));
    c_pkt_err: cover property (@(posedge clk_sys) disable iff (!nrst) rxRegularPacketError);
endmodule
`default_nettype wire

// ---- sle_link_partner.sv ----
// Behavioural far end of the link: recovered clock and lane indications.
// Assumes the bench calls send to place one indication word for n link cycles.
`default_nettype none
module sle_link_partner (
    output logic                  recClk,   // Free-running recovered clock
    output var sle_pkg::sle_link_in_t linkOut   // Lane indications
);
    timeunit 1ns;
    timeprecision 100ps;

    // Recovered clock runs free, 125 ns period; lanes idle at start
    initial begin
        recClk = 1'b0;
        linkOut = '0;
    end
    always #62.5 recClk = ~recClk;

    // Values change on the falling edge so each spans a full rising edge
    // The sender marks packets bad only through the word it is handed
    task automatic send(input sle_pkg::sle_link_in_t v, input int n);
        @(negedge recClk);
        linkOut <= v;
        repeat (n) @(negedge recClk);
        linkOut <= '0;
    endtask
endmodule
`default_nettype wire

// ---- test_serial_link_error_status.sv ----
// Self-checking bench for the link error status block and its APB registers.
// Assumes the far end model drives recClk and linkIn; a second instance
// built with resend shares the bus and the lanes.
`default_nettype none
module test_serial_link_error_status;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned WIN = 32;
    localparam int unsigned LIM = sle_pkg::ERR_LIMIT_DEF;
    logic                  clk_sys = 1'b0;
    logic                  nrst    = 1'b0;
    logic                  psel    = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [7:0]            paddr   = 8'h00;
    logic [31:0]           pwdata  = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  recClk;
    sle_pkg::sle_link_in_t linkIn;
    sle_pkg::sle_status_t  statusPort;
    logic                  rxReg;
    logic                  rxPri;
    logic                  train;
    logic                  rxPriR;
    logic                  resendR;
    logic [7:0]            obs;
    logic [31:0]           rd;
    logic                  err;
    int                    n_mismatch = 0;
    int                    checks     = 0;

    // Observed events: 0 up, 1 cat, 2 link, 3 data, 4 train, 5 reg, 6 pri, 7 resend
    assign obs = {resendR, rxPri, rxReg, train, statusPort};

    always #5 clk_sys = ~clk_sys;

    // Block under test and a resend-built twin on the same lanes and bus
    sle_error_status #(.RETRY_ON_ERROR(1'b0), .ERR_WINDOW(WIN)) sle_error_status_i (
        .clk_sys(clk_sys), .nrst(nrst), .recClk(recClk), .linkIn(linkIn),
        .statusPort(statusPort), .rxRegularPacketError(rxReg),
        .rxPriorityPacketError(rxPri), .priorityResendReq(), .linkTrain(train),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sle_error_status #(.RETRY_ON_ERROR(1'b1), .ERR_WINDOW(WIN)) sle_error_status_r_i (
        .clk_sys(clk_sys), .nrst(nrst), .recClk(recClk), .linkIn(linkIn),
        .statusPort(), .rxRegularPacketError(), .rxPriorityPacketError(rxPriR),
        .priorityResendReq(resendR), .linkTrain(), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(),
        .pslverr());
    sle_link_partner sle_link_partner_i (.recClk(recClk), .linkOut(linkIn));

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        n_mismatch++;
        $display("CHECK FAILED %s expected event seen timeout", what);
        end_of_test();
    endtask

    task automatic reset_dut();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    // One APB transfer; ready, data and error taken at a rising edge, then released
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timeout("apb ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_bit(input int idx);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (obs[idx] !== 1'b1 && n < 400);
        if (n >= 400) timeout($sformatf("event %0d", idx));
    endtask

    // Send lane word x for cnt link cycles and wait for event idx; pulses must end
    task automatic ev(input logic [17:0] x, input int cnt, input int idx);
        fork
            sle_link_partner_i.send(sle_pkg::sle_link_in_t'(x), cnt);
        join_none
        wait_bit(idx);
        if (idx >= 2 && idx != 4) begin
            @(negedge clk_sys);
            check($sformatf("pulse %0d ends", idx), obs[idx], 1'b0);
        end
        wait fork;
    endtask

    task automatic bring_up();
        ev(18'h00001, 1, 0);
        check("train after up", train, 1'b0);
    endtask

    // Main sequence
    initial begin
        reset_dut();
        apb(sle_pkg::REG_STATUS, 1'b0, 32'h0);
        check("state init", rd[5:4], 2'h1);
        apb(sle_pkg::REG_CTRL, 1'b0, 32'h0);
        check("ctrl reset", rd[1:0], 2'h1);
        apb(8'h0c, 1'b0, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        bring_up();
        // Code, disparity and CRC faults: data errors only
        for (int i = 0; i < 3; i++) begin
            ev(18'(18'h20000 >> i), 1, 3);
            check("up after data error", obs[0], 1'b1);
        end
        repeat (WIN + 4) @(posedge recClk);
        ev(18'h07000, 1, 5);
        ev(18'h23800, 1, 6);
        ev(18'h23800, 1, 7);
        check("resend build pri flag", rxPriR, 1'b0);
        check("up after packets", obs[0], 1'b1);
        repeat (WIN + 4) @(posedge recClk);
        apb(sle_pkg::REG_CTRL, 1'b1, 32'h3);
        apb(sle_pkg::REG_ERRCNT, 1'b0, 32'h0);
        check("errcnt clear", rd, 32'h0);
        // Restart, lane losses and overflows each drop and retrain the link
        for (int i = 4; i <= 10; i++) begin
            ev(18'(18'h1 << i), 1, 2);
            check("down after link error", obs[0], 1'b0);
            wait_bit(4);
            bring_up();
        end
        apb(sle_pkg::REG_ERRCNT, 1'b0, 32'h0);
        check("link drops", rd, 32'h0007_0000);
        ev(18'h20000, 2 * LIM - 1, 2);
        apb(sle_pkg::REG_ERRCNT, 1'b0, 32'h0);
        check("escalated drops", rd[31:16], 16'h0008);
        bring_up();
        apb(sle_pkg::REG_CTRL, 1'b1, 32'h0);
        // With the link disabled a link error leaves it down
        ev(18'h00020, 1, 2);
        apb(sle_pkg::REG_STATUS, 1'b0, 32'h0);
        check("disabled state", rd[5:0], 6'h00);
        apb(sle_pkg::REG_CTRL, 1'b1, 32'h1);
        apb(sle_pkg::REG_STATUS, 1'b0, 32'h0);
        check("enabled state", rd[5:4], 2'h1);
        // Polarity, lane reversal and scrambled order are permanent
        for (int i = 3; i >= 1; i--) begin
            bring_up();
            ev(18'(18'h1 << i), 1, 1);
            ev(18'h00001, 1, 1);
            check("dead stays down", obs[0], 1'b0);
            apb(sle_pkg::REG_STATUS, 1'b0, 32'h0);
            check("dead state", rd[5:0], 6'h32);
            reset_dut();
        end
        end_of_test();
    end
endmodule
`default_nettype wire
